// file: design/acs_divider.sv
`timescale 1ns/1ps
`default_nettype none
module acs_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Count control
  input wire logic en,
  input wire logic [15:0] limit,
  // One-cycle tick
  output logic tick
);
  logic [15:0] cnt_ff;

  // Limit of zero or one ticks on every enable
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 16'h0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        if (cnt_ff + 16'h1 >= limit) begin
          cnt_ff <= 16'h0;
          tick <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 16'h1;
        end
      end
    end
  end

  AST_TICK_CAUSE: assert property (@(posedge clock) disable iff (!reset_n)
    tick |-> $past(en))
    else $error("divider ticked without enable");
endmodule
`default_nettype wire

// file: design/acs_packer.sv
`timescale 1ns/1ps
`default_nettype none
module acs_packer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Sample capture
  input wire logic start,
  input wire logic accel_en,
  input wire logic temp_en,
  input wire acs_sample_t sample,
  // Byte push
  output logic push_valid,
  output logic [7:0] push_byte
);
  logic [7:0] pend_ff;
  logic [63:0] data_ff;
  logic [2:0] pick;

  // Lowest pending slot goes first
  always_comb begin
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend_ff[i]) pick = 3'(i);
    end
  end

  // A new sample restarts the sequence; bytes left over are dropped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= 8'h0;
      data_ff <= 64'h0;
      push_valid <= 1'b0;
      push_byte <= 8'h0;
    end else if (start) begin
      data_ff <= sample;
      pend_ff <= {{2{temp_en}}, {6{accel_en}}};
      push_valid <= 1'b0;
    end else if (pend_ff != 8'h0) begin
      push_valid <= 1'b1;
      push_byte <= data_ff[6'(63 - 8 * pick) -: 8];
      pend_ff[pick] <= 1'b0;
    end else begin
      push_valid <= 1'b0;
    end
  end

  sequence s_lone_start;
    start ##1 !start;
  endsequence

  AST_ACCEL_ORDER: assert property (@(posedge clock) disable iff (!reset_n)
    start && accel_en ##1 !start ##1 !start |->
      push_valid && push_byte == $past(sample.x[15:8], 2) ##1
      push_valid && push_byte == $past(sample.x[7:0], 3))
    else $error("accel bytes out of order");
  AST_TEMP_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
    (!accel_en && temp_en && start) ##0 s_lone_start ##1 !start |->
      push_valid && push_byte == $past(sample.temp[15:8], 2) && !$past(push_valid) ##1
      push_valid && push_byte == $past(sample.temp[7:0], 3))
    else $error("temperature bytes wrong");
  AST_NO_QUEUE: assert property (@(posedge clock) disable iff (!reset_n)
    (!accel_en && !temp_en && start) ##0 s_lone_start |=> !push_valid)
    else $error("bytes queued with sources off");
endmodule
`default_nettype wire

// file: design/acs_pkg.sv
package acs_pkg;
  // Clock and derived rates
  localparam int CLK_HZ = 40_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int INT_RATE_HZ = 1000;
  localparam int BYP_RATE_HZ = 4000;
  localparam int US_CYC = CLK_HZ / US_PER_S;
  localparam int MS_CYC = CLK_HZ / INT_RATE_HZ;
  localparam int BYP_CYC = CLK_HZ / BYP_RATE_HZ;
  // Sensor on-time per wake, microseconds
  localparam int TON_4X_US = 1840;
  localparam int TON_8X_US = 2840;
  localparam int TON_16X_US = 4840;
  localparam int TON_32X_US = 8840;
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_DIV = 6'h19;
  localparam logic [5:0] IDX_RANGE = 6'h1c;
  localparam logic [5:0] IDX_FILT = 6'h1d;
  localparam logic [5:0] IDX_LPRATE = 6'h1e;
  localparam logic [5:0] IDX_THR = 6'h1f;
  localparam logic [5:0] IDX_QSEL = 6'h23;
  localparam logic [5:0] IDX_STAT = 6'h24;
  localparam logic [5:0] IDX_CLR = 6'h25;
  localparam logic [5:0] IDX_IEN = 6'h26;
  localparam logic [5:0] IDX_PWR = 6'h27;
  // Writable bit masks
  localparam logic [7:0] MASK_RANGE = 8'hf8;
  localparam logic [7:0] MASK_FILT = 8'h3f;
  localparam logic [7:0] MASK_LPRATE = 8'h0f;
  localparam logic [7:0] MASK_QSEL = 8'h88;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Field positions
  localparam int SELFTEST_LSB = 5;
  localparam int RANGE_LSB = 3;
  localparam int AVG_LSB = 4;
  localparam int BYP_BIT = 3;
  localparam int TEMP_Q_BIT = 7;
  localparam int ACC_Q_BIT = 3;
  localparam int IRQ_DRDY = 0;
  localparam int IRQ_MOTION = 1;
  // Field values
  localparam logic [3:0] WAKE_MIN = 4'h4;
  localparam logic [3:0] WAKE_MAX = 4'hb;
  localparam logic [8:0] WAKE_SLOW_MS = 9'h100;
  localparam logic [2:0] LPF_WIDE = 3'h7;
  localparam logic [5:0] AVG_MIN = 6'h4;
  // Motion threshold scaling
  localparam int MG_PER_LSB = 4;
  localparam int MG_PER_G = 1000;
  localparam int LSB_PER_G = 16384;

  typedef struct packed {
    logic [2:0] selftest;
    logic [1:0] range;
    logic bypass;
    logic [2:0] lowpass;
  } acs_cfg_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [15:0] temp;
  } acs_sample_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_AWAKE = 2'b10
  } acs_state_t;
endpackage

// file: design/acs_sampler.sv
// Overview of operation
// - Range code selects 2, 4, 8, 16 g
// - Averaging code picks 4 to 32 samples
// - Bypass skips filter, 4 kHz rate
// - Filter code picks bandwidth at 1 kHz
// - Output rate divided by one plus divider
// - Low power duty-cycles sensor per averaging
// - Wake codes 4 to 11 set rate
// - Wake rate counter always runs, used only with duty-cycling
// - Motion threshold is 4 mg per count
// - Temperature bytes queued when enabled
// - Six accel bytes queued, X to Z
// - Divider only with filter codes 1-6
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acs_sampler
  import acs_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int BYP_CYCLES = BYP_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Sensor front end
  input wire acs_sample_t sample_in,
  output acs_cfg_t sensor_cfg,
  output logic [5:0] avg_samples,
  output logic sensor_on,
  // Queue push
  output logic push_valid,
  output logic [7:0] push_byte,
  // Interrupt
  output logic irq
);
  logic [7:0] div_ff, range_ff, filt_ff, lprate_ff, thr_ff, qsel_ff;
  logic [1:0] stat_ff, ien_ff;
  logic duty_en_ff;
  acs_state_t state_ff, nxt_state;
  logic [13:0] on_us_ff, nxt_on_us, ton_us;
  acs_sample_t prev_ff;
  logic prev_valid_ff;
  logic req, wr, aligned;
  logic [5:0] idx;
  logic [7:0] rd;
  logic [1:0] rng, avg_code, clr, evt;
  logic bypass, div_act, wake_ok, on_done, sample_evt, motion_evt;
  logic [2:0] lp_code, hit;
  logic [3:0] wake_code;
  logic [15:0] base_limit, div_limit, wake_limit;
  logic us_tick, base_tick, div_tick, wake_tick;
  logic [29:0] rhs;
  logic [63:0] cur_vec, old_vec;

  assign rng = range_ff[RANGE_LSB +: 2];
  assign avg_code = filt_ff[AVG_LSB +: 2];
  assign bypass = filt_ff[BYP_BIT];
  assign lp_code = filt_ff[2:0];
  assign wake_code = lprate_ff[3:0];

  // Bus decode; one wait state, ack on the second cycle
  assign req = wb_cyc && wb_stb && !wb_ack;
  assign aligned = wb_adr[1:0] == 2'h0;
  assign idx = wb_adr[7:2];
  assign wr = req && wb_we && wb_sel[0] && aligned;
  assign clr = (wr && idx == IDX_CLR) ? wb_dat_w[1:0] : 2'h0;

  always_comb begin
    rd = 8'h0;
    if (aligned) begin
      case (idx)
        IDX_DIV: rd = div_ff;
        IDX_RANGE: rd = range_ff;
        IDX_FILT: rd = filt_ff;
        IDX_LPRATE: rd = lprate_ff;
        IDX_THR: rd = thr_ff;
        IDX_QSEL: rd = qsel_ff;
        IDX_STAT: rd = {6'h0, stat_ff};
        IDX_IEN: rd = {6'h0, ien_ff};
        IDX_PWR: rd = {7'h0, duty_en_ff};
        default: rd = 8'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0;
    end else begin
      wb_ack <= req;
      wb_dat_r <= (req && !wb_we) ? {24'h0, rd} : 32'h0;
    end
  end

  // Masks keep reserved bits at zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= RST_REG;
      range_ff <= RST_REG;
      filt_ff <= RST_REG;
      lprate_ff <= RST_REG;
      thr_ff <= RST_REG;
      qsel_ff <= RST_REG;
      ien_ff <= 2'h0;
      duty_en_ff <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_DIV: div_ff <= wb_dat_w[7:0];
        IDX_RANGE: range_ff <= wb_dat_w[7:0] & MASK_RANGE;
        IDX_FILT: filt_ff <= wb_dat_w[7:0] & MASK_FILT;
        IDX_LPRATE: lprate_ff <= wb_dat_w[7:0] & MASK_LPRATE;
        IDX_THR: thr_ff <= wb_dat_w[7:0];
        IDX_QSEL: qsel_ff <= wb_dat_w[7:0] & MASK_QSEL;
        IDX_IEN: ien_ff <= wb_dat_w[1:0];
        IDX_PWR: duty_en_ff <= wb_dat_w[0];
        default: ;
      endcase
    end
  end

  // Event in the clearing cycle survives
  assign evt = {motion_evt, sample_evt};
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff <= 2'h0;
      irq <= 1'b0;
    end else begin
      stat_ff <= (stat_ff & ~clr) | evt;
      irq <= |(stat_ff & ien_ff);
    end
  end

  // Settings seen by the analog front end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sensor_cfg <= '0;
      avg_samples <= AVG_MIN;
    end else begin
      sensor_cfg.selftest <= range_ff[SELFTEST_LSB +: 3];
      sensor_cfg.range <= rng;
      sensor_cfg.bypass <= bypass;
      sensor_cfg.lowpass <= lp_code;
      avg_samples <= AVG_MIN << avg_code;
    end
  end

  // Rate chain; low power always runs on the 1 kHz base
  assign base_limit = (bypass && !duty_en_ff) ? 16'(BYP_CYCLES) : 16'(MS_CYCLES);
  assign div_act = !bypass && lp_code != 3'h0 && lp_code != LPF_WIDE;
  assign div_limit = div_act ? 16'({8'h0, div_ff} + 16'h1) : 16'h1;
  assign wake_ok = wake_code >= WAKE_MIN && wake_code <= WAKE_MAX;
  assign wake_limit = 16'(WAKE_SLOW_MS >> (wake_code - WAKE_MIN));

  acs_divider u_us (
    .clock(clock),
    .reset_n(reset_n),
    .en(1'b1),
    .limit(16'(US_CYC)),
    .tick(us_tick)
  );
  acs_divider u_base (
    .clock(clock),
    .reset_n(reset_n),
    .en(1'b1),
    .limit(base_limit),
    .tick(base_tick)
  );
  acs_divider u_rate (
    .clock(clock),
    .reset_n(reset_n),
    .en(base_tick),
    .limit(div_limit),
    .tick(div_tick)
  );
  acs_divider u_wake (
    .clock(clock),
    .reset_n(reset_n),
    .en(base_tick),
    .limit(wake_limit),
    .tick(wake_tick)
  );

  always_comb begin
    case (avg_code)
      2'h0: ton_us = 14'(TON_4X_US);
      2'h1: ton_us = 14'(TON_8X_US);
      2'h2: ton_us = 14'(TON_16X_US);
      default: ton_us = 14'(TON_32X_US);
    endcase
  end

  // Wakes that arrive while awake are skipped, not queued
  assign on_done = us_tick && (on_us_ff + 14'h1 >= ton_us);
  assign sample_evt = (state_ff == ST_RUN && div_tick) || (state_ff == ST_AWAKE && on_done);
  always_comb begin
    nxt_state = state_ff;
    nxt_on_us = on_us_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (duty_en_ff) nxt_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!duty_en_ff) begin
          nxt_state = ST_RUN;
        end else if (wake_tick && wake_ok) begin
          nxt_state = ST_AWAKE;
          nxt_on_us = 14'h0;
        end
      end
      ST_AWAKE: begin
        if (!duty_en_ff) begin
          nxt_state = ST_RUN;
        end else if (on_done) begin
          nxt_state = ST_SLEEP;
        end else if (us_tick) begin
          nxt_on_us = on_us_ff + 14'h1;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_RUN;
      on_us_ff <= 14'h0;
      sensor_on <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      on_us_ff <= nxt_on_us;
      sensor_on <= nxt_state != ST_SLEEP;
    end
  end

  // Motion compare in 2 g counts so the threshold ignores range
  assign cur_vec = sample_in;
  assign old_vec = prev_ff;
  assign rhs = 30'(thr_ff) * 30'(MG_PER_LSB * LSB_PER_G);
  for (genvar g = 0; g < 3; g++) begin : g_axis
    logic [15:0] cur, old;
    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [29:0] lhs;
    assign cur = cur_vec[63 - 16 * g -: 16];
    assign old = old_vec[63 - 16 * g -: 16];
    assign diff = $signed({cur[15], cur}) - $signed({old[15], old});
    assign mag = diff[16] ? 17'(-diff) : 17'(diff);
    assign lhs = (30'(mag) << rng) * 30'(MG_PER_G);
    assign hit[g] = lhs >= rhs;
  end
  assign motion_evt = sample_evt && state_ff == ST_AWAKE && prev_valid_ff && (|hit);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= '0;
      prev_valid_ff <= 1'b0;
    end else if (sample_evt) begin
      prev_ff <= sample_in;
      prev_valid_ff <= 1'b1;
    end
  end

  acs_packer u_pack (
    .clock(clock),
    .reset_n(reset_n),
    .start(sample_evt),
    .accel_en(qsel_ff[ACC_Q_BIT]),
    .temp_en(qsel_ff[TEMP_Q_BIT]),
    .sample(sample_in),
    .push_valid(push_valid),
    .push_byte(push_byte)
  );

  // Checker helpers
  logic chg_ff;
  logic [15:0] gap_ff, nbase_ff;
  logic [13:0] hlp_us_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chg_ff <= 1'b1;
      gap_ff <= 16'h1;
      nbase_ff <= 16'h0;
      hlp_us_ff <= 14'h0;
    end else begin
      if ($changed(base_limit) || $changed(div_limit)) chg_ff <= 1'b1;
      else if (div_tick) chg_ff <= 1'b0;
      gap_ff <= base_tick ? 16'h1 : gap_ff + 16'h1;
      if (div_tick) nbase_ff <= {15'h0, base_tick};
      else if (base_tick) nbase_ff <= nbase_ff + 16'h1;
      hlp_us_ff <= (state_ff == ST_AWAKE) ? hlp_us_ff + {13'h0, us_tick} : 14'h0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_write(logic [5:0] r);
    wr && idx == r;
  endsequence
  sequence s_leave_awake;
    state_ff == ST_AWAKE ##1 state_ff == ST_SLEEP;
  endsequence

  AST_RANGE: assert property (s_write(IDX_RANGE) |-> ##2 sensor_cfg.range == $past(wb_dat_w[4:3], 2))
    else $error("range not applied");
  AST_AVG: assert property (s_write(IDX_FILT) |-> ##2 avg_samples == (AVG_MIN << $past(wb_dat_w[5:4], 2)))
    else $error("averaging count wrong");
  AST_BASE_GAP: assert property (base_tick && !chg_ff && !duty_en_ff && $stable(base_limit)
    |-> gap_ff == base_limit)
    else $error("internal rate period wrong");
  AST_LOWPASS: assert property (s_write(IDX_FILT) |-> ##2 sensor_cfg.lowpass == $past(wb_dat_w[2:0], 2))
    else $error("filter code not applied");
  AST_DIV_COUNT: assert property (div_tick && !chg_ff && $stable(div_limit) && $stable(base_limit)
    |-> nbase_ff == div_limit)
    else $error("rate divider count wrong");
  AST_TON: assert property (s_leave_awake |-> hlp_us_ff == ton_us && !sensor_on)
    else $error("on-time wrong");
  AST_WAKE_RSVD: assert property (state_ff == ST_SLEEP && !wake_ok |=> state_ff != ST_AWAKE)
    else $error("reserved wake code woke sensor");
  AST_RUN_NO_WAKE: assert property (!duty_en_ff |=> state_ff == ST_RUN ##0 sensor_on)
    else $error("duty-cycling without enable");
  AST_MOTION: assert property (motion_evt |=> stat_ff[IRQ_MOTION])
    else $error("motion event lost");
  AST_RSVD_ZERO: assert property (req && !wb_we && aligned && idx == IDX_RANGE |=> wb_ack && wb_dat_r[2:0] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acs_pkg::*;
  // Short base counts keep the run small
  localparam int MS_T = 40;
  localparam int BYP_T = 10;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  acs_sample_t sample_in = '0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  acs_cfg_t sensor_cfg;
  logic [5:0] avg_samples;
  logic sensor_on;
  logic push_valid;
  logic [7:0] push_byte;
  logic irq;
  logic prev_pv = 1'b1;
  int mismatches = 0;
  int n_compared = 0;
  logic [5:0] ridx [8] = '{IDX_DIV, IDX_RANGE, IDX_FILT, IDX_LPRATE, IDX_THR, IDX_QSEL, IDX_IEN, IDX_PWR};
  logic [7:0] rmask [8] = '{8'hff, MASK_RANGE, MASK_FILT, MASK_LPRATE, 8'hff, MASK_QSEL, 8'h03, 8'h01};
  logic [7:0] pfilt [5] = '{8'h08, 8'h00, 8'h03, 8'h07, 8'h01};
  logic [7:0] pdiv [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h04};
  int pexp [5] = '{BYP_T, MS_T, 3 * MS_T, MS_T, 5 * MS_T};
  logic [7:0] qsel [4] = '{8'h88, 8'h08, 8'h80, 8'h00};

  always #12.5 clock = ~clock;
  always @(posedge clock) prev_pv <= push_valid;

  acs_sampler #(.MS_CYCLES(MS_T), .BYP_CYCLES(BYP_T)) acs_sampler_inst (
    .clock(clock), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sample_in(sample_in),
    .sensor_cfg(sensor_cfg), .avg_samples(avg_samples), .sensor_on(sensor_on), .push_valid(push_valid),
    .push_byte(push_byte), .irq(irq)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Master holds the request until ack is sampled, then releases
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] data, input logic [3:0] sel,
                      output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat_w <= {24'h0, data};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_r[7:0];
    if (n >= 50) mismatches++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] data);
    logic [7:0] d;
    xfer(1'b1, idx, data, 4'h1, d);
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] v);
    xfer(1'b0, idx, 8'h00, 4'h1, v);
  endtask

  // Cycles from here to the next start of a byte group
  task automatic wait_rise(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(push_valid === 1'b1 && prev_pv === 1'b0) && n < 3000);
  endtask

  function automatic acs_cfg_t exp_cfg(input logic [7:0] a, input logic [7:0] b);
    acs_cfg_t c;
    c.selftest = a[7:5];
    c.range = a[4:3];
    c.bypass = b[3];
    c.lowpass = b[2:0];
    return c;
  endfunction

  function automatic logic [7:0] exp_byte(input acs_sample_t s, input int j);
    logic [63:0] w;
    w = s;
    return w[63 - 8 * j -: 8];
  endfunction

  initial begin
    // Longest test is the low-power on-time, about 74k cycles
    repeat (95000) @(posedge clock);
    mismatches++;
    summarize();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] a;
    logic [7:0] b;
    int n;
    int nb;
    void'($urandom(32'h69d9));
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    sample_in <= {$urandom, $urandom};
    check(sensor_cfg, 9'h0);
    check(avg_samples, 6'h4);
    for (int i = 0; i < 8; i++) begin
      rd(ridx[i], v);
      check(v, RST_REG);
    end
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom);
      if (i == 7) a[0] = 1'b0;
      wr(ridx[i], a);
      rd(ridx[i], v);
      check(v, a & rmask[i]);
    end
    wr(6'h30, 8'hff);
    rd(6'h30, v);
    check(v, 8'h00);
    wr(IDX_THR, 8'h3c);
    xfer(1'b1, IDX_THR, 8'h5a, 4'h0, v);
    rd(IDX_THR, v);
    check(v, 8'h3c);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      a = (i < 4) ? {3'(i), 2'(i), 3'h0} : 8'($urandom);
      b = (i < 4) ? {2'h0, 2'(i), 1'b1, 3'(i)} : 8'($urandom);
      wr(IDX_RANGE, a);
      wr(IDX_FILT, b);
      repeat (3) @(posedge clock);
      check(sensor_cfg, exp_cfg(a, b));
      check(avg_samples, AVG_MIN << b[5:4]);
    end
    $display("test config done");
    // Wake code is set but duty-cycling is off, so rates stay those of the filter path
    // Accel bytes only, so every sample gives exactly one rising push edge
    wr(IDX_QSEL, 8'h08);
    wr(IDX_LPRATE, 8'h0b);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_FILT, pfilt[i]);
      wr(IDX_DIV, pdiv[i]);
      repeat (230) @(posedge clock);
      wait_rise(n);
      wait_rise(n);
      check(n, pexp[i]);
    end
    $display("test rates done");
    wr(IDX_FILT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_QSEL, qsel[i]);
      nb = (qsel[i][3] ? 6 : 0) + (qsel[i][7] ? 2 : 0);
      repeat (60) @(posedge clock);
      wait_rise(n);
      for (int j = 0; j < nb; j++) begin
        check(push_valid, 1'b1);
        check(push_byte, exp_byte(sample_in, qsel[i][3] ? j : j + 6));
        @(posedge clock);
      end
      check(push_valid, 1'b0);
    end
    $display("test queue done");
    wr(IDX_IEN, 8'h01);
    repeat (60) @(posedge clock);
    check(irq, 1'b1);
    wr(IDX_LPRATE, 8'h00);
    wr(IDX_PWR, 8'h01);
    repeat (20) @(posedge clock);
    wr(IDX_IEN, 8'h00);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    wr(IDX_IEN, 8'h01);
    repeat (3) @(posedge clock);
    check(irq, 1'b1);
    wr(IDX_CLR, 8'h03);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    // Reserved wake code: the sensor must never wake, so status stays clear
    repeat (300) @(posedge clock);
    rd(IDX_STAT, v);
    check(v, 8'h00);
    rd(IDX_CLR, v);
    check(v, 8'h00);
    $display("test interrupt done");
    wr(IDX_FILT, 8'h07);
    wr(IDX_LPRATE, 8'h0b);
    n = 0;
    while (sensor_on !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (sensor_on === 1'b1 && n < 80000) begin
      @(posedge clock);
      n++;
    end
    // On-time counts whole microseconds of a free-running tick, so it ends inside the last one
    check(n > (TON_4X_US - 1) * US_CYC && n <= TON_4X_US * US_CYC, 1'b1);
    repeat (20) @(posedge clock);
    rd(IDX_STAT, v);
    check(v[0], 1'b1);
    $display("test low power done");
    summarize();
  end
endmodule
`default_nettype wire
